// [src/xcv_pkg.sv]
// Package: constants and types for the bidirectional latch/flop transceiver
package xcv_pkg;
	// -------------------------------------------------------------------------
	// Data path
	// -------------------------------------------------------------------------
	localparam int XCV_WIDTH = 18;
	localparam int XCV_FIFO_DEPTH = 16;
	// -------------------------------------------------------------------------
	// Register byte offsets
	// -------------------------------------------------------------------------
	localparam logic [7:0] XCV_OFF_CTRL = 8'h00;
	localparam logic [7:0] XCV_OFF_STATUS = 8'h04;
	localparam logic [7:0] XCV_OFF_SNOOP = 8'h08;
	localparam logic [7:0] XCV_OFF_AB_VAL = 8'h0c;
	localparam logic [7:0] XCV_OFF_BA_VAL = 8'h10;
	localparam logic [7:0] XCV_OFF_PINS = 8'h14;
	// -------------------------------------------------------------------------
	// Field positions and reset values
	// -------------------------------------------------------------------------
	localparam int XCV_CTRL_SNOOP_EN_BIT = 0;
	localparam int XCV_STAT_OVF_BIT = 0;
	localparam int XCV_STAT_EMPTY_BIT = 1;
	localparam int XCV_STAT_LEVEL_LSB = 8;
	localparam logic [31:0] XCV_CTRL_RESET = 32'h0000_0000;
	// Per-direction control pins, packed together
	typedef struct packed {
		logic clk_en_n;
		logic out_en_n;
		logic latch_en;
		logic clock;
	} xcv_ctl_t;
endpackage : xcv_pkg

// [src/xcv_fifo.sv]
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/100ps
module xcv_fifo #(
	parameter int WIDTH = 18,
	parameter int DEPTH = 16
) (
	input wire logic clk, // Clock
	input wire logic rst_n, // Async reset, active low
	input wire logic in_valid, // Write request
	output logic in_ready, // Room for a word
	input wire logic [WIDTH-1:0] in_data, // Write data
	output logic out_valid, // Word available
	input wire logic out_ready, // Consumer takes head
	output logic [WIDTH-1:0] out_data, // Head word
	output logic [$clog2(DEPTH):0] level // Words held
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wp_r;
	logic [AW-1:0] rp_r;
	logic [AW:0] cnt_r;
	wire push = in_valid && in_ready;
	wire pop = out_valid && out_ready;

	// Full and empty come straight from the count so they never disagree
	assign in_ready = (cnt_r != AW'(0) + (AW+1)'(DEPTH)) ? 1'b1 : 1'b0;
	assign out_valid = (cnt_r != '0);
	assign out_data = mem[rp_r];
	assign level = cnt_r;

	// Storage has no reset; only pointers and count do
	always_ff @(posedge clk) begin
		if (push) begin
			mem[wp_r] <= in_data;
		end
	end

	// Pointers and count
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wp_r <= '0;
			rp_r <= '0;
			cnt_r <= '0;
		end else begin
			if (push) wp_r <= wp_r + AW'(1);
			if (pop) rp_r <= rp_r + AW'(1);
			cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule : xcv_fifo

// [src/xcv_path.sv]
// One transfer direction: latch stage, flop stage and output enable
`timescale 1ns/100ps
module xcv_path #(
	parameter int WIDTH = 18
) (
	input wire logic clk, // System clock
	input wire logic rst_n, // Async reset, active low
	input wire logic [WIDTH-1:0] src, // Source port data
	input xcv_pkg::xcv_ctl_t ctl, // Direction control pins
	output logic [WIDTH-1:0] dst_r, // Destination port value
	output logic dst_oe_r, // Destination drive enable
	output logic [WIDTH-1:0] store_r, // Held word
	output logic cap_r // Pulse: flop captured
);
	logic clk_prev_r;
	logic clk_seen_r;
	logic [WIDTH-1:0] store_nxt;

	// ---------------------------------------------------------------------
	// Stage decode
	// ---------------------------------------------------------------------
	// Control pin edge is seen as a sampled low-to-high step
	// History is trusted only one cycle after reset, so a clock resting high is no edge
	wire clk_rise = ctl.clock && !clk_prev_r && clk_seen_r;
	// Flop loads only with latch closed and clock enable low; enable high inhibits
	wire flop_load = clk_rise && !ctl.clk_en_n && !ctl.latch_en;
	// Latch high: transparent, and the last value seen is kept at the fall
	assign store_nxt = ctl.latch_en ? src : (flop_load ? src : store_r);

	// Held word and clock history
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			store_r <= '0;
			clk_prev_r <= 1'b0;
			clk_seen_r <= 1'b0;
			cap_r <= 1'b0;
		end else begin
			store_r <= store_nxt;
			clk_prev_r <= ctl.clock;
			clk_seen_r <= 1'b1;
			cap_r <= flop_load;
		end
	end

	// Output stage: no inversion; drive only while output enable is low
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			dst_r <= '0;
			dst_oe_r <= 1'b0;
		end else begin
			dst_r <= ctl.latch_en ? src : store_nxt;
			dst_oe_r <= !ctl.out_en_n;
		end
	end
endmodule : xcv_path

// [src/xcv_top.sv]
// Top: 18-bit bidirectional transceiver with APB status and capture snoop
`timescale 1ns/100ps
// Function
// - Each direction carries 18 bits through a latch and a flop stage.
// - Destination data keeps source polarity in every mode.
// - A-to-B flop takes A data on clock rise while clock enable is low.
// - A-to-B latch holds A data when latch enable falls.
// - Clock enable and latch enable low keep stored data, clock high or low.
// - Latch enable high makes the path transparent.
// - Output enable low drives B with the path value.
// - Output enable high puts B in high impedance.
// - B-to-A path works alike with its own four controls.
// - Undriven A inputs keep their last valid level.
// - With enables and clock low, B keeps its earlier level.
module xcv_top #(
	parameter int WIDTH = xcv_pkg::XCV_WIDTH,
	parameter int FIFO_DEPTH = xcv_pkg::XCV_FIFO_DEPTH
) (
	input wire logic pclk, // APB clock, 40 MHz
	input wire logic presetn, // Async reset, active low
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB direction
	input wire logic [7:0] paddr, // APB byte address
	input wire logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error
	input wire logic [WIDTH-1:0] a_in, // A port pin level
	input wire logic a_driven, // Far side drives A port
	output logic [WIDTH-1:0] a_out, // A port drive value
	output logic a_oe, // A port drive enable
	input wire logic [WIDTH-1:0] b_in, // B port pin level
	output logic [WIDTH-1:0] b_out, // B port drive value
	output logic b_oe, // B port drive enable
	input wire logic a_to_b_clk_en_n, // A-to-B clock enable, low active
	input wire logic a_to_b_out_en_n, // A-to-B output enable, low active
	input wire logic a_to_b_latch_en, // A-to-B latch enable
	input wire logic a_to_b_clock, // A-to-B clock pin
	input wire logic b_to_a_clk_en_n, // B-to-A clock enable, low active
	input wire logic b_to_a_out_en_n, // B-to-A output enable, low active
	input wire logic b_to_a_latch_en, // B-to-A latch enable
	input wire logic b_to_a_clock // B-to-A clock pin
);
	localparam int LW = $clog2(FIFO_DEPTH) + 1;

	// -------------------------------------------------------------------------
	// Declarations
	// -------------------------------------------------------------------------
	xcv_pkg::xcv_ctl_t ab_ctl;
	xcv_pkg::xcv_ctl_t ba_ctl;
	logic [WIDTH-1:0] a_hold_r;
	logic [WIDTH-1:0] a_src;
	logic [WIDTH-1:0] ab_store;
	logic [WIDTH-1:0] ba_store;
	logic ab_cap;
	logic ctrl_snoop_en_r;
	logic ovf_r;
	logic ovf_nxt;
	logic [31:0] prdata_r;
	logic [31:0] rdata_nxt;
	logic pready_r;
	logic pslverr_r;
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic [WIDTH-1:0] fifo_out_data;
	logic [LW-1:0] fifo_level;
	logic [WIDTH-1:0] a_pin_r;
	logic [WIDTH-1:0] b_pin_r;

	// Checks that an offset is one of the mapped registers
	function automatic logic is_mapped(input logic [7:0] addr);
		is_mapped = (addr == xcv_pkg::XCV_OFF_CTRL) || (addr == xcv_pkg::XCV_OFF_STATUS) ||
			(addr == xcv_pkg::XCV_OFF_SNOOP) || (addr == xcv_pkg::XCV_OFF_AB_VAL) ||
			(addr == xcv_pkg::XCV_OFF_BA_VAL) || (addr == xcv_pkg::XCV_OFF_PINS);
	endfunction : is_mapped

	// -------------------------------------------------------------------------
	// Port A bus hold
	// -------------------------------------------------------------------------
	// A floating input would otherwise feed an unknown into the latch
	assign a_src = a_driven ? a_in : a_hold_r;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			a_hold_r <= '0;
		end else begin
			a_hold_r <= a_src;
		end
	end

	// -------------------------------------------------------------------------
	// Both directions
	// -------------------------------------------------------------------------
	// Pins packed per direction; each path only sees its own four controls
	assign ab_ctl = '{clk_en_n: a_to_b_clk_en_n, out_en_n: a_to_b_out_en_n,
		latch_en: a_to_b_latch_en, clock: a_to_b_clock};
	assign ba_ctl = '{clk_en_n: b_to_a_clk_en_n, out_en_n: b_to_a_out_en_n,
		latch_en: b_to_a_latch_en, clock: b_to_a_clock};

	xcv_path #(.WIDTH(WIDTH)) u_ab (
		.clk(pclk),
		.rst_n(presetn),
		.src(a_src),
		.ctl(ab_ctl),
		.dst_r(b_out),
		.dst_oe_r(b_oe),
		.store_r(ab_store),
		.cap_r(ab_cap)
	);

	// Same structure reused so the reverse direction cannot drift apart
	xcv_path #(.WIDTH(WIDTH)) u_ba (
		.clk(pclk),
		.rst_n(presetn),
		.src(b_in),
		.ctl(ba_ctl),
		.dst_r(a_out),
		.dst_oe_r(a_oe),
		.store_r(ba_store),
		.cap_r()
	);

	// Pin snapshot for software; limitation: both enables low is not blocked here
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			a_pin_r <= '0;
			b_pin_r <= '0;
		end else begin
			a_pin_r <= a_src;
			b_pin_r <= b_in;
		end
	end

	// -------------------------------------------------------------------------
	// Capture snoop FIFO
	// -------------------------------------------------------------------------
	// Each A-to-B flop capture is logged while the CTRL snoop enable is set; a full FIFO drops the word and flags it
	wire snoop_push = ab_cap && ctrl_snoop_en_r;
	wire acc_edge = psel && penable && pready_r;
	wire wr_acc = acc_edge && pwrite;
	wire rd_pop = acc_edge && !pwrite && (paddr == xcv_pkg::XCV_OFF_SNOOP) && fifo_out_valid;

	xcv_fifo #(.WIDTH(WIDTH), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clk(pclk),
		.rst_n(presetn),
		.in_valid(snoop_push),
		.in_ready(fifo_in_ready),
		.in_data(ab_store),
		.out_valid(fifo_out_valid),
		.out_ready(rd_pop),
		.out_data(fifo_out_data),
		.level(fifo_level)
	);

	// -------------------------------------------------------------------------
	// APB register file
	// -------------------------------------------------------------------------
	// Overflow: a drop in the clearing cycle keeps the flag set
	wire ovf_clr = wr_acc && (paddr == xcv_pkg::XCV_OFF_STATUS) && pwdata[xcv_pkg::XCV_STAT_OVF_BIT];
	assign ovf_nxt = (snoop_push && !fifo_in_ready) ? 1'b1 : (ovf_clr ? 1'b0 : ovf_r);

	// Read mux, loaded in the setup cycle so data is stable during access
	always_comb begin
		rdata_nxt = 32'h0000_0000;
		case (paddr)
			xcv_pkg::XCV_OFF_CTRL: rdata_nxt[xcv_pkg::XCV_CTRL_SNOOP_EN_BIT] = ctrl_snoop_en_r;
			xcv_pkg::XCV_OFF_STATUS: begin
				rdata_nxt[xcv_pkg::XCV_STAT_OVF_BIT] = ovf_r;
				rdata_nxt[xcv_pkg::XCV_STAT_EMPTY_BIT] = !fifo_out_valid;
				rdata_nxt[xcv_pkg::XCV_STAT_LEVEL_LSB +: LW] = fifo_level;
			end
			xcv_pkg::XCV_OFF_SNOOP: rdata_nxt[WIDTH-1:0] = fifo_out_valid ? fifo_out_data : '0;
			xcv_pkg::XCV_OFF_AB_VAL: rdata_nxt[WIDTH-1:0] = ab_store;
			xcv_pkg::XCV_OFF_BA_VAL: rdata_nxt[WIDTH-1:0] = ba_store;
			xcv_pkg::XCV_OFF_PINS: rdata_nxt = {6'h00, a_to_b_latch_en, b_to_a_latch_en,
				a_to_b_out_en_n, b_to_a_out_en_n, a_pin_r[WIDTH-1 -: 11], b_pin_r[WIDTH-1 -: 11]};
			default: rdata_nxt = 32'h0000_0000;
		endcase
	end

	// Handshake: no wait state, ready raised for the first access cycle only
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r <= 32'h0000_0000;
		end else begin
			pready_r <= psel && !penable;
			pslverr_r <= psel && !penable && !is_mapped(paddr);
			prdata_r <= (psel && !penable && !pwrite) ? rdata_nxt : 32'h0000_0000;
		end
	end

	// Control and sticky status
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_snoop_en_r <= xcv_pkg::XCV_CTRL_RESET[xcv_pkg::XCV_CTRL_SNOOP_EN_BIT];
			ovf_r <= 1'b0;
		end else begin
			if (wr_acc && (paddr == xcv_pkg::XCV_OFF_CTRL)) begin
				ctrl_snoop_en_r <= pwdata[xcv_pkg::XCV_CTRL_SNOOP_EN_BIT];
			end
			ovf_r <= ovf_nxt;
		end
	end

	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;
endmodule : xcv_top

// [bench/xcv_top_monitor.sv]
// Checker on the transceiver top ports
`timescale 1ns/100ps
module xcv_top_monitor #(
	parameter int WIDTH = 18
) (
	input wire logic pclk, // Clock
	input wire logic presetn, // Reset
	input wire logic [WIDTH-1:0] a_in, // A pins
	input wire logic a_driven, // A driven
	input wire logic [WIDTH-1:0] a_out, // A value
	input wire logic a_oe, // A enable
	input wire logic [WIDTH-1:0] b_in, // B pins
	input wire logic [WIDTH-1:0] b_out, // B value
	input wire logic b_oe, // B enable
	input wire logic a_to_b_clk_en_n, // Ctl
	input wire logic a_to_b_out_en_n, // Ctl
	input wire logic a_to_b_latch_en, // Ctl
	input wire logic a_to_b_clock, // Ctl
	input wire logic b_to_a_clk_en_n, // Ctl
	input wire logic b_to_a_out_en_n, // Ctl
	input wire logic b_to_a_latch_en, // Ctl
	input wire logic b_to_a_clock // Ctl
);
	// ----
	// Clock history
	// ----
	logic ab_q;
	logic ba_q;
	// Last clock levels, so a rise is seen as 0 then 1
	always_ff @(posedge pclk) begin
		ab_q <= a_to_b_clock;
		ba_q <= b_to_a_clock;
	end
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	// Rise with the latch shut on both cycles, so no latch edge mixes in
	sequence s_ab_cap;
		!ab_q && a_to_b_clock && !a_to_b_clk_en_n && !a_to_b_latch_en && !$past(a_to_b_latch_en) && a_driven;
	endsequence
	// Latch shut and no enabled clock rise: the held word must not move
	sequence s_ab_keep;
		!a_to_b_latch_en && !(!ab_q && a_to_b_clock && !a_to_b_clk_en_n);
	endsequence
	sequence s_ba_cap;
		!ba_q && b_to_a_clock && !b_to_a_clk_en_n && !b_to_a_latch_en && !$past(b_to_a_latch_en);
	endsequence
	a_ab_capture: assert property (s_ab_cap |=> b_out == $past(a_in))
		else $error("ab capture");
	a_ab_hold: assert property (s_ab_keep |=> $stable(b_out))
		else $error("ab hold");
	a_ab_transparent: assert property (a_to_b_latch_en && a_driven |=> b_out == $past(a_in))
		else $error("ab transparent");
	a_ab_drive: assert property (!a_to_b_out_en_n |=> b_oe)
		else $error("ab drive");
	a_ab_isolate: assert property (a_to_b_out_en_n |=> !b_oe)
		else $error("ab isolate");
	a_ba_capture: assert property (s_ba_cap |=> a_out == $past(b_in))
		else $error("ba capture");
	a_ba_transparent: assert property (b_to_a_latch_en |=> a_out == $past(b_in))
		else $error("ba transparent");
	a_ba_isolate: assert property (b_to_a_out_en_n |=> !a_oe)
		else $error("ba isolate");
	a_ba_drive: assert property (!b_to_a_out_en_n |=> a_oe)
		else $error("ba drive");
endmodule : xcv_top_monitor

// [bench/xcv_far_side.sv]
// Card logic and backplane agent around the transceiver pins
`timescale 1ns/100ps
module xcv_far_side (
	input wire logic [17:0] dat, // Offered word
	input wire logic card_drv, // Card drives A
	input wire logic plane_drv, // Agent drives B
	input wire logic [17:0] a_out, // Device A value
	input wire logic a_oe, // Device A enable
	input wire logic [17:0] b_out, // Device B value
	input wire logic b_oe, // Device B enable
	output logic [17:0] a_in, // A pin level
	output logic a_driven, // Card drives A
	output logic [17:0] b_in // B pin level
);
	// Released A lines show the inverse, so a stale word never matches by luck
	assign a_in = card_drv ? dat : (a_oe ? a_out : ~dat);
	assign a_driven = card_drv;
	// Backplane termination pulls idle lines high
	assign b_in = b_oe ? b_out : (plane_drv ? dat : 18'h3ffff);
endmodule : xcv_far_side

// [bench/testbench.sv]
// Self-checking bench for the transceiver top
`timescale 1ns/100ps
module testbench;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, rv;
	logic pready, pslverr, re, a_driven, a_oe, b_oe;
	logic [17:0] a_in, a_out, b_in, b_out;
	logic [17:0] dat = 18'h0;
	logic [1:0] drv_sel = 2'b10; // Card on A, agent idle
	xcv_pkg::xcv_ctl_t ab = 4'b1100;
	xcv_pkg::xcv_ctl_t ba = 4'b1100;
	int err_count = 0;
	int checks_done = 0;
	always #12.5 pclk = ~pclk;
	xcv_top xcv_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .a_in(a_in),
		.a_driven(a_driven), .a_out(a_out), .a_oe(a_oe), .b_in(b_in), .b_out(b_out), .b_oe(b_oe),
		.a_to_b_clk_en_n(ab.clk_en_n), .a_to_b_out_en_n(ab.out_en_n), .a_to_b_latch_en(ab.latch_en),
		.a_to_b_clock(ab.clock), .b_to_a_clk_en_n(ba.clk_en_n), .b_to_a_out_en_n(ba.out_en_n),
		.b_to_a_latch_en(ba.latch_en), .b_to_a_clock(ba.clock));
	xcv_far_side xcv_far_side_inst (.dat(dat), .card_drv(drv_sel[1]), .plane_drv(drv_sel[0]), .a_out(a_out),
		.a_oe(a_oe), .b_out(b_out), .b_oe(b_oe), .a_in(a_in), .a_driven(a_driven), .b_in(b_in));
	// ----
	// Tasks
	// ----
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_count++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	// Pins change on one edge, then three edges let the registered paths settle
	task automatic drv(input logic [3:0] c, input logic [3:0] e, input logic [17:0] d, input logic [1:0] v);
		@(posedge pclk);
		ab <= c;
		ba <= e;
		dat <= d;
		drv_sel <= v;
		repeat (3) @(posedge pclk);
		#1;
	endtask : drv
	// Request held until pready is sampled high; watchdog bounds the wait
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rv = prdata;
		re = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic rchk(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(rv, e);
	endtask : rchk
	task automatic final_report();
		if (err_count == 0 && checks_done > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : final_report
	// ----
	// Sequence
	// ----
	initial begin
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		rchk(xcv_pkg::XCV_OFF_CTRL, 32'h0);
		apb(1'b0, 8'h40, 32'h0);
		chk(32'(re), 32'h1);
		drv(4'b1010, 4'b1100, 18'h2a5c3, 2'b10);
		chk(32'(b_out), 32'h2a5c3);
		chk(32'(b_oe), 32'h1);
		drv(4'b1000, 4'b1100, 18'h2a5c3, 2'b10);
		drv(4'b1001, 4'b1100, 18'h15a3c, 2'b10);
		chk(32'(b_out), 32'h2a5c3);
		rchk(xcv_pkg::XCV_OFF_AB_VAL, 32'h2a5c3);
		drv(4'b0000, 4'b1100, 18'h15a3c, 2'b10);
		drv(4'b0001, 4'b1100, 18'h15a3c, 2'b10);
		chk(32'(b_out), 32'h15a3c);
		drv(4'b0000, 4'b1100, 18'h3ffff, 2'b10);
		chk(32'(b_out), 32'h15a3c);
		drv(4'b1010, 4'b1100, 18'h0f0f0, 2'b10);
		drv(4'b1010, 4'b1100, 18'h30303, 2'b00);
		chk(32'(b_out), 32'h0f0f0);
		drv(4'b1110, 4'b1100, 18'h0f0f0, 2'b10);
		chk(32'(b_oe), 32'h0);
		rchk(xcv_pkg::XCV_OFF_PINS, 32'h02cf_0fff);
		drv(4'b1100, 4'b1010, 18'h1c71c, 2'b01);
		chk(32'(a_out), 32'h1c71c);
		chk(32'(a_oe), 32'h1);
		drv(4'b1100, 4'b0000, 18'h0e38e, 2'b01);
		drv(4'b1100, 4'b0001, 18'h0e38e, 2'b01);
		chk(32'(a_out), 32'h0e38e);
		rchk(xcv_pkg::XCV_OFF_BA_VAL, 32'h0e38e);
		// Seventeen captures into a sixteen-word snoop buffer: the last is dropped
		apb(1'b1, xcv_pkg::XCV_OFF_CTRL, 32'h1);
		for (int i = 0; i < 17; i++) begin
			drv(4'b0100, 4'b1100, 18'(i * 37), 2'b10);
			drv(4'b0101, 4'b1100, 18'(i * 37), 2'b10);
		end
		chk(32'(b_out), 32'd592);
		rchk(xcv_pkg::XCV_OFF_STATUS, 32'h1001);
		apb(1'b1, xcv_pkg::XCV_OFF_STATUS, 32'h1);
		for (int i = 0; i < 16; i++) begin
			rchk(xcv_pkg::XCV_OFF_SNOOP, 32'(i * 37));
		end
		rchk(xcv_pkg::XCV_OFF_STATUS, 32'h2);
		rchk(xcv_pkg::XCV_OFF_SNOOP, 32'h0);
		final_report();
	end
	// Watchdog well beyond the few hundred cycles the sequence needs
	initial begin
		#(25 * 5000);
		err_count++;
		final_report();
	end
endmodule : testbench
bind xcv_top xcv_top_monitor #(.WIDTH(WIDTH)) xcv_top_monitor_inst (.*);
